// ===== logic/flash_rd_device.sv
// Purpose: Flash device end of the multi-I/O read link with continuous read mode.
// Assumes: mem_rdata is a combinational read of mem_addr on the same clock.
// Notes: The link pins are sampled by clk; sck must stay below clk/8.
//
// Overview of operation
// - Quad-output opcodes take three or four address bytes.
// - Quad-output read inserts latency-code dummy cycles.
// - Quad data: one nibble per falling edge.
// - Address increments per byte, wraps at top.
// - Dual I/O opcodes take three or four bytes.
// - Dual data: two bits per falling edge.
// - Host sends instruction, address, four mode clocks.
// - Dual mode nibble A keeps continuous read.
// - Other dual mode nibble ends it at deselect.
// - Mode reset command leaves continuous read.
// - Host releases IO by first data edge.
// - Host may release IO early in mode/dummy.
// - Host keeps select low through mode, dummy.
// - Quad I/O opcodes take three or four bytes.
// - Quad I/O needs quad enable or quad bit.
// - Quad I/O: two mode clocks, then dummies.
// - Quad mode nibble A keeps continuous read.
// - Other quad mode nibble ends it at deselect.
// - Four-wire mode takes instructions four bits wide.
// - Address length bit selects four address bytes.
// - Dummies count falling to falling edge.
// - Deselect ends read and returns to idle.
`timescale 1ns/100ps
module flash_rd_device
  import flash_rd_pkg::*;
#(
  parameter int ARRAY_AW = 25
) (
  input wire logic clk,
  input wire logic rst,
  flash_link_if.dev link,
  input wire logic [7:0] cfg_one,
  input wire logic [7:0] cfg_two,
  input wire logic [7:0] cfg_three,
  output logic [ARRAY_AW-1:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic cont_active
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_MODE = 3'b011,
    ST_DUMMY = 3'b100,
    ST_DATA = 3'b101,
    ST_SKIP = 3'b110
  } dev_state_t;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [5:0] meta_ff;
  logic [5:0] pins_ff;
  logic sck_d_ff;
  logic cs_d_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 6'h3e;
      pins_ff <= 6'h3e;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      meta_ff <= {link.io, link.cs_n, link.sck};
      pins_ff <= meta_ff;
      sck_d_ff <= pins_ff[0];
      cs_d_ff <= pins_ff[1];
    end
  end

  logic sck_s;
  logic cs_s;
  logic [3:0] io_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign sck_s = pins_ff[0];
  assign cs_s = pins_ff[1];
  assign io_s = pins_ff[5:2];
  assign sck_rise = ~cs_s & sck_s & ~sck_d_ff;
  assign sck_fall = ~cs_s & ~sck_s & sck_d_ff;
  assign cs_fall = ~cs_s & cs_d_ff;
  assign cs_rise = cs_s & ~cs_d_ff;

  // ---------------------------------------------------------------
  // Command, address and mode capture
  // ---------------------------------------------------------------
  dev_state_t state_ff;
  logic [5:0] cnt_ff;
  logic [31:0] in_sh_ff;
  logic [7:0] op_ff;
  rd_kind_t kind_ff;
  logic [LAT_W-1:0] lat_ff;
  logic cont_ff;
  logic [7:0] cont_op_ff;

  logic addr_len;
  logic quad_ok;
  logic [2:0] lanes;
  logic last_bits;
  logic [31:0] nxt_in;
  rd_kind_t nxt_kind;
  rd_kind_t cont_kind;
  logic ld_addr;
  logic mode_done;
  logic lat_zero;

  assign addr_len = cfg_two[CFG2_ADDR_LEN_BIT];
  assign quad_ok = cfg_one[CFG1_QUAD_EN_BIT] | cfg_two[CFG2_QUAD_CAP_BIT];
  assign lanes = (state_ff == ST_CMD) ?
                 (cfg_two[CFG2_FOUR_WIRE_BIT] ? LANES_FOUR : LANES_ONE) : kind_ff.alanes;
  assign last_bits = cnt_ff <= {3'h0, lanes};
  assign nxt_in = take_lanes(in_sh_ff, io_s, lanes);
  assign nxt_kind = decode_read(nxt_in[7:0], addr_len);
  assign cont_kind = decode_read(cont_op_ff, addr_len);
  assign ld_addr = sck_rise & (state_ff == ST_ADDR) & last_bits;
  assign mode_done = sck_rise & (state_ff == ST_MODE) & last_bits;
  assign lat_zero = lat_ff == '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      in_sh_ff <= '0;
      op_ff <= '0;
      kind_ff <= '0;
      lat_ff <= '0;
    end else if (cs_s) begin
      state_ff <= ST_IDLE;
    end else if (cs_fall) begin
      in_sh_ff <= '0;
      if (cont_ff) begin
        // A continuous read opens straight into the address phase.
        state_ff <= ST_ADDR;
        op_ff <= cont_op_ff;
        kind_ff <= cont_kind;
        cnt_ff <= addr_bits(cont_kind.wide);
      end else begin
        state_ff <= ST_CMD;
        cnt_ff <= OPC_BITS;
      end
    end else if (sck_rise) begin
      in_sh_ff <= nxt_in;
      cnt_ff <= cnt_ff - {3'h0, lanes};
      case (state_ff)
        ST_CMD: begin
          if (last_bits) begin
            // Opcode bits must not leak into the top of a short address.
            in_sh_ff <= '0;
            op_ff <= nxt_in[7:0];
            kind_ff <= nxt_kind;
            cnt_ff <= addr_bits(nxt_kind.wide);
            if (nxt_kind.ok & (quad_ok | nxt_kind.alanes != LANES_FOUR)) begin
              state_ff <= ST_ADDR;
            end else begin
              state_ff <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (last_bits) begin
            lat_ff <= cfg_three[LAT_LSB +: LAT_W];
            cnt_ff <= MODE_BITS;
            state_ff <= kind_ff.has_mode ? ST_MODE : ST_DUMMY;
          end
        end
        ST_MODE: begin
          if (last_bits) begin
            state_ff <= ST_DUMMY;
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall & (state_ff == ST_DUMMY)) begin
      // Dummy cycles run from one falling edge to the next; zero means data now.
      if (lat_zero) begin
        state_ff <= ST_DATA;
      end else begin
        lat_ff <= lat_ff - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data output
  // ---------------------------------------------------------------
  logic [ARRAY_AW-1:0] addr_ff;
  logic [7:0] byte_sh_ff;
  logic [1:0] beat_ff;
  logic [3:0] io_o_ff;
  logic [3:0] io_oe_ff;
  logic drive;
  logic [7:0] cur_byte;
  logic last_beat;

  assign drive = sck_fall & ((state_ff == ST_DATA) | (state_ff == ST_DUMMY & lat_zero));
  assign cur_byte = (beat_ff == 2'h0) ? mem_rdata : byte_sh_ff;
  assign last_beat = (kind_ff.dlanes == LANES_FOUR) ? (beat_ff == 2'h1) : (beat_ff == 2'h3);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_ff <= '0;
      byte_sh_ff <= '0;
      beat_ff <= '0;
      io_o_ff <= '0;
      io_oe_ff <= '0;
    end else if (cs_s) begin
      io_oe_ff <= '0;
    end else if (ld_addr) begin
      addr_ff <= nxt_in[ARRAY_AW-1:0];
      beat_ff <= '0;
    end else if (drive) begin
      io_o_ff <= pack_lanes(cur_byte, kind_ff.dlanes);
      io_oe_ff <= (kind_ff.dlanes == LANES_FOUR) ? 4'hf : 4'h3;
      byte_sh_ff <= shift_lanes(cur_byte, kind_ff.dlanes);
      beat_ff <= last_beat ? 2'h0 : beat_ff + 2'h1;
      if (beat_ff == 2'h0) begin
        // The counter is as wide as the array, so it rolls over to zero.
        addr_ff <= addr_ff + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Continuous read mode
  // ---------------------------------------------------------------
  logic cont_next_ff;
  logic mode_seen_ff;
  logic ones_ff;
  logic clk_seen_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cont_ff <= 1'b0;
      cont_op_ff <= '0;
      cont_next_ff <= 1'b0;
      mode_seen_ff <= 1'b0;
      ones_ff <= 1'b0;
      clk_seen_ff <= 1'b0;
    end else if (cs_fall) begin
      mode_seen_ff <= 1'b0;
      ones_ff <= 1'b1;
      clk_seen_ff <= 1'b0;
    end else if (cs_rise) begin
      // The decision taken from the mode bits lands only at deselect.
      // An all-ones frame is the mode reset and outranks its own mode bits.
      if (ones_ff & clk_seen_ff) begin
        cont_ff <= 1'b0;
      end else if (mode_seen_ff) begin
        cont_ff <= cont_next_ff;
      end
    end else if (mode_done) begin
      cont_next_ff <= nxt_in[7:4] == CONT_NIBBLE;
      cont_op_ff <= op_ff;
      mode_seen_ff <= 1'b1;
    end else if (sck_rise & (state_ff == ST_CMD | state_ff == ST_ADDR)) begin
      // An all-ones frame, full opcode or cut short, is the mode reset.
      clk_seen_ff <= 1'b1;
      ones_ff <= ones_ff & (pack_lanes(8'hff, lanes) == (io_s & pack_lanes(8'hff, lanes)));
    end
  end

  assign mem_addr = addr_ff;
  assign cont_active = cont_ff;
  assign link.d_io_o = io_o_ff;
  assign link.d_io_oe = io_oe_ff;

endmodule

// ===== logic/flash_rd_pkg.sv
// Purpose: Shared constants, types and helpers for the multi-I/O flash read link.
// Assumes: Read commands only; single-lane and DDR reads are not part of this link.
// Notes: Both ends decode the read opcodes with the same function.
package flash_rd_pkg;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_OUT_W = 8'h6c;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_DUAL_IO_W = 8'hbc;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_QUAD_IO_W = 8'hec;
  localparam logic [7:0] OP_MODE_RESET = 8'hff;
  localparam logic [3:0] CONT_NIBBLE = 4'ha;

  // ---------------------------------------------------------------
  // Configuration bit positions and field widths
  // ---------------------------------------------------------------
  localparam int CFG2_ADDR_LEN_BIT = 0;
  localparam int CFG2_QUAD_CAP_BIT = 1;
  localparam int CFG2_FOUR_WIRE_BIT = 3;
  localparam int CFG1_QUAD_EN_BIT = 1;
  localparam int LAT_LSB = 0;
  localparam int LAT_W = 4;

  // ---------------------------------------------------------------
  // Phase lengths in bits and lane counts
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
  localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [2:0] LANES_ONE = 3'h1;
  localparam logic [2:0] LANES_TWO = 3'h2;
  localparam logic [2:0] LANES_FOUR = 3'h4;

  typedef struct packed {
    logic ok;
    logic wide;
    logic has_mode;
    logic [2:0] alanes;
    logic [2:0] dlanes;
  } rd_kind_t;

  function automatic rd_kind_t decode_read(input logic [7:0] op, input logic addr_len);
    rd_kind_t k;
    k = '{ok: 1'b1, wide: addr_len, has_mode: 1'b0, alanes: LANES_ONE, dlanes: LANES_FOUR};
    case (op)
      OP_QUAD_OUT: k.wide = addr_len;
      OP_QUAD_OUT_W: k.wide = 1'b1;
      OP_DUAL_IO, OP_DUAL_IO_W: begin
        k.wide = (op == OP_DUAL_IO_W) | addr_len;
        k.has_mode = 1'b1;
        k.alanes = LANES_TWO;
        k.dlanes = LANES_TWO;
      end
      OP_QUAD_IO, OP_QUAD_IO_W: begin
        k.wide = (op == OP_QUAD_IO_W) | addr_len;
        k.has_mode = 1'b1;
        k.alanes = LANES_FOUR;
      end
      default: k.ok = 1'b0;
    endcase
    return k;
  endfunction

  // Top bits of a byte placed on the lanes, highest bit on the highest lane.
  function automatic logic [3:0] pack_lanes(input logic [7:0] v, input logic [2:0] lanes);
    if (lanes == LANES_FOUR) return v[7:4];
    else if (lanes == LANES_TWO) return {2'h0, v[7:6]};
    else return {3'h0, v[7]};
  endfunction

  function automatic logic [7:0] shift_lanes(input logic [7:0] v, input logic [2:0] lanes);
    if (lanes == LANES_FOUR) return {v[3:0], 4'h0};
    else if (lanes == LANES_TWO) return {v[5:0], 2'h0};
    else return {v[6:0], 1'h0};
  endfunction

  function automatic logic [31:0] take_lanes(input logic [31:0] sh, input logic [3:0] io,
                                             input logic [2:0] lanes);
    if (lanes == LANES_FOUR) return {sh[27:0], io};
    else if (lanes == LANES_TWO) return {sh[29:0], io[1:0]};
    else return {sh[30:0], io[0]};
  endfunction

  function automatic logic [5:0] addr_bits(input logic wide);
    return wide ? ADDR_BITS_LONG : ADDR_BITS_SHORT;
  endfunction

endpackage

// ===== logic/flash_link_if.sv
// Purpose: Pins between the flash read controller and the flash device.
// Assumes: IO lines idle high through a pull-up when nobody drives them.
// Notes: The wire level is resolved here from both output enables.
`timescale 1ns/100ps
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  assign io = (h_io_oe & h_io_o) | (d_io_oe & d_io_o) | ~(h_io_oe | d_io_oe);

  modport host (output sck, output cs_n, output h_io_o, output h_io_oe, input io);
  modport dev (input sck, input cs_n, input io, output d_io_o, output d_io_oe);
endinterface

// ===== logic/flash_rd_host.sv
// Purpose: Host controller end that runs one read transfer on the flash link.
// Assumes: The caller picks opcode, address, mode byte and dummy count.
// Notes: sck is derived from clk; its half period is SCK_HALF clocks.
`timescale 1ns/100ps
module flash_rd_host
  import flash_rd_pkg::*;
#(
  parameter int SCK_HALF = 8
) (
  input wire logic clk,
  input wire logic rst,
  flash_link_if.host link,
  input wire logic start,
  input wire logic [7:0] op,
  input wire logic skip_cmd,
  input wire logic four_wire,
  input wire logic addr_len,
  input wire logic [31:0] addr,
  input wire logic [7:0] mode,
  input wire logic [3:0] dummy,
  input wire logic [15:0] nbytes,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic busy
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CMD = 3'b001,
    H_ADDR = 3'b010,
    H_MODE = 3'b011,
    H_DUMMY = 3'b100,
    H_DATA = 3'b101,
    H_END = 3'b110,
    H_GAP = 3'b111
  } host_state_t;

  // ---------------------------------------------------------------
  // Clock divider and input synchroniser
  // ---------------------------------------------------------------
  host_state_t state_ff;
  logic [7:0] div_ff;
  logic sck_ff;
  logic [3:0] io_meta_ff;
  logic [3:0] io_s_ff;
  logic tick;
  logic rise;
  logic fall;

  assign tick = (state_ff != H_IDLE) & (div_ff == 8'(SCK_HALF - 1));
  assign rise = tick & ~sck_ff & (state_ff != H_END) & (state_ff != H_GAP);
  assign fall = tick & sck_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
      sck_ff <= 1'b0;
      io_meta_ff <= '0;
      io_s_ff <= '0;
    end else begin
      io_meta_ff <= link.io;
      io_s_ff <= io_meta_ff;
      div_ff <= (tick | state_ff == H_IDLE) ? 8'h00 : div_ff + 8'h01;
      sck_ff <= sck_ff ^ (rise | fall);
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  rd_kind_t kind_ff;
  logic four_ff;
  logic cs_n_ff;
  logic [5:0] cnt_ff;
  logic [3:0] dcnt_ff;
  logic [15:0] left_ff;
  logic [63:0] tx_ff;
  logic [31:0] rx_ff;
  logic [5:0] rx_bits_ff;
  logic [3:0] io_o_ff;
  logic [3:0] io_oe_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  rd_kind_t k;
  logic [63:0] tx0;
  logic [2:0] lanes0;
  logic [2:0] lanes;
  logic last_bits;
  logic [31:0] nxt_rx;

  assign k = decode_read(op, addr_len);
  assign tx0 = k.wide ? {op, addr, mode, 16'h0000} : {op, addr[23:0], mode, 24'h000000};
  assign lanes0 = skip_cmd ? k.alanes : (four_wire ? LANES_FOUR : LANES_ONE);
  assign lanes = (state_ff == H_CMD) ? (four_ff ? LANES_FOUR : LANES_ONE) :
                 (state_ff == H_DATA) ? kind_ff.dlanes : kind_ff.alanes;
  assign last_bits = cnt_ff <= {3'h0, lanes};
  assign nxt_rx = take_lanes(rx_ff, io_s_ff, lanes);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= H_IDLE;
      kind_ff <= '0;
      four_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      cnt_ff <= '0;
      dcnt_ff <= '0;
      left_ff <= '0;
      tx_ff <= '0;
      rx_ff <= '0;
      rx_bits_ff <= '0;
      io_o_ff <= '0;
      io_oe_ff <= '0;
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= 1'b0;
      case (state_ff)
        H_IDLE: begin
          if (start & (nbytes != 16'h0000)) begin
            kind_ff <= k;
            four_ff <= four_wire;
            cs_n_ff <= 1'b0;
            left_ff <= nbytes;
            dcnt_ff <= dummy;
            state_ff <= skip_cmd ? H_ADDR : H_CMD;
            cnt_ff <= skip_cmd ? addr_bits(k.wide) : OPC_BITS;
            io_o_ff <= pack_lanes(skip_cmd ? tx0[55:48] : tx0[63:56], lanes0);
            io_oe_ff <= pack_lanes(8'hff, lanes0);
            tx_ff <= (skip_cmd ? {tx0[55:0], 8'h00} : tx0) << lanes0;
          end
        end
        H_END: begin
          if (tick & ~sck_ff) begin
            cs_n_ff <= 1'b1;
            state_ff <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            state_ff <= H_IDLE;
          end
        end
        default: begin
          if (rise) begin
            cnt_ff <= cnt_ff - {3'h0, lanes};
            // Select stays low from the mode bits to the last byte.
            case (state_ff)
              H_CMD: if (last_bits) begin
                state_ff <= H_ADDR;
                cnt_ff <= addr_bits(kind_ff.wide);
              end
              H_ADDR: if (last_bits) begin
                cnt_ff <= MODE_BITS;
                state_ff <= kind_ff.has_mode ? H_MODE : (dcnt_ff == 4'h0 ? H_DATA : H_DUMMY);
                rx_bits_ff <= '0;
              end
              H_MODE: if (last_bits) begin
                state_ff <= (dcnt_ff == 4'h0) ? H_DATA : H_DUMMY;
              end
              H_DUMMY: begin
                dcnt_ff <= dcnt_ff - 4'h1;
                if (dcnt_ff == 4'h1) begin
                  state_ff <= H_DATA;
                end
              end
              default: begin
                rx_ff <= nxt_rx;
                rx_bits_ff <= (rx_bits_ff + {3'h0, lanes} == MODE_BITS) ? 6'h00 : rx_bits_ff + {3'h0, lanes};
                if (rx_bits_ff + {3'h0, lanes} == MODE_BITS) begin
                  rdata_ff <= nxt_rx[7:0];
                  rvalid_ff <= 1'b1;
                  left_ff <= left_ff - 16'h0001;
                  if (left_ff == 16'h0001) begin
                    state_ff <= H_END;
                  end
                end
              end
            endcase
          end else if (fall) begin
            if (state_ff == H_CMD | state_ff == H_ADDR | state_ff == H_MODE) begin
              io_o_ff <= pack_lanes(tx_ff[63:56], lanes);
              io_oe_ff <= pack_lanes(8'hff, lanes);
              tx_ff <= tx_ff << lanes;
            end else begin
              io_oe_ff <= 4'h0;
            end
          end
        end
      endcase
    end
  end

  assign link.sck = sck_ff;
  assign link.cs_n = cs_n_ff;
  assign link.h_io_o = io_o_ff;
  assign link.h_io_oe = io_oe_ff;
  assign rdata = rdata_ff;
  assign rvalid = rvalid_ff;
  assign busy = state_ff != H_IDLE;

endmodule

// ===== verification/flash_link_properties.sv
// Purpose: Concurrent checks on the flash read link pins.
// Assumes: Both ends are design modules joined by one interface.
// Notes: SCK_HALF must equal the value given to the host end.
`timescale 1ns/100ps
module flash_link_properties #(
  parameter int SCK_HALF = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe,
  input wire logic [3:0] io
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] hi_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hi_ff <= 8'h00;
    else hi_ff <= sck ? hi_ff + 8'h01 : 8'h00;
  end
  property p_no_clash; (h_io_oe & d_io_oe) == 4'h0; endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive io");
  property p_oe_width; d_io_oe inside {4'h0, 4'h3, 4'hf}; endproperty
  a_oe_width: assert property (p_oe_width) else $error("bad device lane set");
  property p_idle_release; cs_n [*6] |-> d_io_oe == 4'h0; endproperty
  a_idle_release: assert property (p_idle_release) else $error("device drives while idle");
  property p_drive_in_frame; $rose(|d_io_oe) |-> !cs_n; endproperty
  a_drive_in_frame: assert property (p_drive_in_frame) else $error("drive outside frame");
  property p_oe_hold; (d_io_oe != 4'h0 && !cs_n) |=> $stable(d_io_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("device drive dropped in frame");
  property p_dev_change_low; (d_io_oe != 4'h0 && $changed(d_io_o)) |-> !sck; endproperty
  a_dev_change_low: assert property (p_dev_change_low) else $error("data moved while sck high");
  property p_host_change_low; (h_io_oe != 4'h0 && $changed(h_io_o)) |-> !sck; endproperty
  a_host_change_low: assert property (p_host_change_low) else $error("host io moved while sck high");
  property p_sck_half; $fell(sck) |-> hi_ff == 8'(SCK_HALF); endproperty
  a_sck_half: assert property (p_sck_half) else $error("sck high time wrong");
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck runs while deselected");
  property p_io_wire; d_io_oe == 4'hf |-> io == d_io_o; endproperty
  a_io_wire: assert property (p_io_wire) else $error("io differs from device drive");
  c_quad: cover property (d_io_oe == 4'hf);
  c_dual: cover property (d_io_oe == 4'h3);
  c_cut: cover property ($rose(cs_n) && d_io_oe != 4'h0);
endmodule

// ===== verification/multi_io_serial_flash_read_test.sv
// Purpose: Self-checking run of host and device ends of the flash read link.
// Assumes: The array is modelled as a fixed function of the address.
// Notes: Random addresses, lengths and latency codes use a fixed seed.
`timescale 1ns/100ps
module multi_io_serial_flash_read_test import flash_rd_pkg::*;;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic clk, rst, start, skip_cmd, four_wire, addr_len, rvalid, busy, cont_active;
  logic [7:0] op, mode, rdata, cfg_one, cfg_two, cfg_three, mem_rdata;
  logic [31:0] addr;
  logic [3:0] dummy;
  logic [15:0] nbytes;
  logic [24:0] mem_addr;
  int err_count, tests_run, cyc;
  logic [7:0] ops [6] = '{OP_QUAD_OUT, OP_QUAD_OUT_W, OP_DUAL_IO, OP_DUAL_IO_W, OP_QUAD_IO, OP_QUAD_IO_W};
  flash_link_if flash_link_if_i ();
  flash_rd_host #(.SCK_HALF(8)) flash_rd_host_i (.clk(clk), .rst(rst), .link(flash_link_if_i), .start(start),
    .op(op), .skip_cmd(skip_cmd), .four_wire(four_wire), .addr_len(addr_len), .addr(addr), .mode(mode),
    .dummy(dummy), .nbytes(nbytes), .rdata(rdata), .rvalid(rvalid), .busy(busy));
  flash_rd_device flash_rd_device_i (.clk(clk), .rst(rst), .link(flash_link_if_i), .cfg_one(cfg_one),
    .cfg_two(cfg_two), .cfg_three(cfg_three), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .cont_active(cont_active));
  flash_link_properties #(.SCK_HALF(8)) flash_link_properties_i (.clk(clk), .rst(rst), .sck(flash_link_if_i.sck),
    .cs_n(flash_link_if_i.cs_n), .h_io_o(flash_link_if_i.h_io_o), .h_io_oe(flash_link_if_i.h_io_oe),
    .d_io_o(flash_link_if_i.d_io_o), .d_io_oe(flash_link_if_i.d_io_oe), .io(flash_link_if_i.io));
  function automatic logic [7:0] exp_byte(input logic [24:0] a);
    return a[7:0] ^ a[15:8] ^ a[24:17];
  endfunction
  assign mem_rdata = exp_byte(mem_addr);
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2);
    @(posedge clk);
    cfg_one <= c1;
    cfg_two <= c2;
    cfg_three <= {4'h0, 4'($urandom)};
  endtask
  // Expected start address follows the wide opcodes or the address length bit.
  task automatic rd(input logic [7:0] o, input logic sk, input logic [31:0] a, input logic [7:0] m, input int n);
    logic [24:0] p;
    @(posedge clk);
    p = (cfg_two[0] | (o[3:0] == 4'hc)) ? a[24:0] : {1'b0, a[23:0]};
    op <= o;
    skip_cmd <= sk;
    addr <= a;
    mode <= m;
    nbytes <= 16'(n);
    dummy <= cfg_three[3:0];
    addr_len <= cfg_two[0];
    four_wire <= cfg_two[3];
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      do @(posedge clk); while (rvalid !== 1'b1);
      if (cfg_one[1] | cfg_two[1] | (o[7:4] != 4'he)) check8(rdata, exp_byte(p));
      else check8(rdata, 8'hff);
      p = p + 25'h1;
    end
    while (busy !== 1'b0) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    {rst, start, skip_cmd, four_wire, addr_len, op, mode, addr, dummy, nbytes} = '0;
    rst = 1'b1;
    {cfg_one, cfg_two, cfg_three} = {8'h02, 8'h00, 8'h00};
    void'($urandom(94));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      cfg(8'h02, {7'h0, 1'($urandom)});
      rd(ops[i % 6], 1'b0, $urandom & 32'h01ffffff, {4'h5, 4'($urandom)}, 1 + $urandom % 4);
    end
    rd(OP_QUAD_OUT_W, 1'b0, 32'h01fffffe, 8'h00, 4);
    for (int k = 2; k < 5; k += 2) begin
      rd(ops[k], 1'b0, $urandom & 32'h01ffffff, 8'ha3, 2);
      check8({7'h0, cont_active}, 8'h01);
      rd(ops[k], 1'b1, $urandom & 32'h01ffffff, 8'h30, 2);
      check8({7'h0, cont_active}, 8'h00);
    end
    rd(OP_QUAD_IO, 1'b0, $urandom & 32'h01ffffff, 8'ha0, 1);
    rd(OP_QUAD_IO, 1'b1, 32'hffffffff, 8'ha0, 1);
    check8({7'h0, cont_active}, 8'h00);
    rd(OP_QUAD_IO, 1'b0, $urandom & 32'h01ffffff, 8'h00, 2);
    cfg(8'h00, 8'h00);
    rd(OP_QUAD_IO, 1'b0, $urandom & 32'h01ffffff, 8'h00, 1);
    cfg(8'h00, 8'h02);
    rd(OP_QUAD_IO, 1'b0, $urandom & 32'h01ffffff, 8'h00, 2);
    cfg(8'h02, 8'h0a);
    rd(OP_QUAD_IO_W, 1'b0, $urandom & 32'h01ffffff, 8'h00, 3);
    end_sim();
  end
endmodule
